// ==== logic/gss_pkg.sv ====
// Package for the servo gain set selector: register map, fields and types.
package gss_pkg;
  // ****
  // Sizes
  // ****
  localparam int GSS_NUM_PARAMS = 13;
  localparam int GSS_PARAM_WIDTH = 16;
  localparam int GSS_TABLE_AW = 6;
  // ****
  // Register offsets
  // ****
  localparam logic [11:0] GSS_CONFIG_OFFSET = 12'h000;
  localparam logic [11:0] GSS_TIMECONST_OFFSET = 12'h004;
  localparam logic [11:0] GSS_STATUS_OFFSET = 12'h008;
  localparam logic [3:0] GSS_TABLE_PAGE = 4'h1;
  // ****
  // Fields and reset values
  // ****
  localparam int GSS_SRC_LSB = 0;
  localparam int GSS_SRC2_LSB = 4;
  localparam int GSS_STOP_BIT = 8;
  localparam int GSS_TRAVEL_BIT = 9;
  localparam int GSS_CONFIG_BITS = 10;
  localparam int GSS_TC_BITS = 4;
  localparam int GSS_REQUEST_BIT = 4;
  localparam logic [9:0] GSS_CONFIG_RESET = 10'h000;
  localparam logic [3:0] GSS_TC_RESET = 4'h4;
  localparam logic [3:0] GSS_SRC_COMMAND = 4'h1;
  localparam logic [3:0] GSS_SRC_DIRECTION = 4'h5;
  localparam logic [3:0] GSS_SRC2_COMMAND = 4'h1;
  localparam logic [3:0] GSS_SRC2_SAME = 4'h2;
  localparam logic [1:0] GSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] GSS_RESP_SLVERR = 2'h2;
  // ****
  // Types
  // ****
  typedef enum logic [1:0] {
    GSS_SET_BASE, GSS_SET_FIRST, GSS_SET_SECOND
  } gss_set_type;
  typedef enum logic [1:0] {
    GSS_MODE_POSITION, GSS_MODE_POSITIONING, GSS_MODE_VELOCITY,
    GSS_MODE_TORQUE
  } gss_mode_type;
  typedef struct packed {
    logic travel_direction_select;
    logic stop_time_switch_select;
    logic [3:0] second_gain_source_select;
    logic [3:0] gain_source_select;
  } gss_cfg_type;
  typedef struct packed {
    logic signed [31:0] pulse_freq;
    logic signed [31:0] speed_cmd;
    logic in_position_flag;
    logic zero_speed_flag;
    gss_mode_type mode;
  } gss_motion_type;
endpackage

// ==== logic/gss_table_mem.sv ====
// Gain table memory with one write port and two registered read ports.
`timescale 1ns/10ps
module gss_table_mem #(
  parameter int WIDTH = 16,
  parameter int AW = 6
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic wr_en, // Write strobe.
  input wire logic [AW-1:0] wr_addr, // Write address.
  input wire logic [WIDTH-1:0] wr_data, // Write data.
  input wire logic [AW-1:0] rd_a_addr, // Read port A address.
  output logic [WIDTH-1:0] rd_a_data, // Read port A data.
  input wire logic [AW-1:0] rd_b_addr, // Read port B address.
  output logic [WIDTH-1:0] rd_b_data // Read port B data.
);
  logic [WIDTH-1:0] mem [2**AW];

  // Cleared at reset so the loops never see an unknown gain.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem <= '{default: '0};
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
    end
  end
endmodule

// ==== logic/gss_gain_ramp.sv ====
// First-order ramp that walks each active gain toward its target value.
`timescale 1ns/10ps
module gss_gain_ramp #(
  parameter int WIDTH = 16,
  parameter int COUNT = 13
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic step_en, // Update one entry this cycle.
  input wire logic [3:0] step_index, // Entry to update.
  input wire logic [WIDTH-1:0] target, // Target value of that entry.
  input wire logic [3:0] shift, // Time constant as a power of two.
  output logic [COUNT-1:0][WIDTH-1:0] gain_out // Present gains.
);
  logic [COUNT-1:0][WIDTH-1:0] next_gain;

  // Each entry moves by a fixed fraction of its remaining distance, so
  // the path is exponential; the last small step lands exactly.
  for (genvar i = 0; i < COUNT; i++) begin : g_entry
    logic signed [WIDTH:0] diff;
    logic signed [WIDTH:0] part;
    always_comb begin
      diff = $signed({1'b0, target}) - $signed({1'b0, gain_out[i]});
      part = diff >>> shift;
      next_gain[i] = gain_out[i];
      if (step_en && step_index == 4'(i)) begin
        if (part == '0) begin
          next_gain[i] = target;
        end else begin
          next_gain[i] = gain_out[i] + part[WIDTH-1:0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_out <= '0;
    end else begin
      gain_out <= next_gain;
    end
  end
endmodule

// ==== logic/gss_selector.sv ====
// Servo gain set selector with AXI4-Lite registers and a gain table.
//
// Contract
// - Source code 1 selects by controller commands.
// - A set of thirteen values switches as a group.
// - Source 5 selects by direction; second code 2 follows.
// - Direction is the sign of the active command.
// - Counter-clockwise is positive, travel setting ignored.
// - Positive gives base, negative the first set.
// - Zero without in-position keeps the set.
// - Zero with in-position gives set two if stop switching.
// - Stop switching acts only in position modes.
// - Zero speed in velocity mode keeps the set.
// - Set two survives a change to velocity mode.
// - A velocity stop gives set two back in position mode.
// - Velocity mode uses the speed command.
// - Status is bit 4 of status words one and five.
`timescale 1ns/10ps
module gss_selector
  import gss_pkg::*;
#(
  parameter int NUM_PARAMS = gss_pkg::GSS_NUM_PARAMS,
  parameter int PARAM_WIDTH = gss_pkg::GSS_PARAM_WIDTH
) (
  input wire logic aclk, // Clock, 200 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [11:0] s_axi_awaddr, // Write byte address.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte lanes.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  output logic [1:0] s_axi_bresp, // Write response code.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  input wire logic [11:0] s_axi_araddr, // Read byte address.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response code.
  input wire logic [15:0] control_word1, // Controller input word one.
  input wire logic [15:0] control_word5, // Controller input word five.
  input wire gss_pkg::gss_motion_type motion, // Commands, flags, mode.
  output logic [15:0] status_word1, // Status output word one.
  output logic [15:0] status_word5, // Status output word five.
  output gss_pkg::gss_set_type active_set, // Selected gain set.
  output logic [NUM_PARAMS-1:0][PARAM_WIDTH-1:0] gain_out // Gains.
);
  import gss_pkg::*;

  // ****
  // Register bus
  // ****
  typedef enum logic [1:0] {
    GSS_RD_IDLE, GSS_RD_WAIT, GSS_RD_FETCH, GSS_RD_RESP
  } gss_rd_state_type;

  gss_cfg_type cfg, next_cfg;
  logic [3:0] time_const, next_time_const;
  logic aw_hold, next_aw_hold;
  logic w_hold, next_w_hold;
  logic [11:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic next_awready, next_wready, next_bvalid;
  logic [1:0] next_bresp;
  logic tbl_wr_en;
  gss_rd_state_type rd_state, next_rd_state;
  logic [11:0] raddr, next_raddr;
  logic next_arready, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [PARAM_WIDTH-1:0] tbl_rd_data;
  logic [31:0] cfg_word, merged;

  assign cfg_word = {{(32 - GSS_CONFIG_BITS){1'b0}}, cfg};

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_cfg = cfg;
    next_time_const = time_const;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    tbl_wr_en = 1'b0;
    merged = cfg_word;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Address and data may come in either order; act once both are held.
    if (aw_hold && w_hold && !s_axi_bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = GSS_RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        if (wstrb[b]) begin
          merged[8*b +: 8] = wdata[8*b +: 8];
        end
      end
      if (waddr[11:2] == GSS_CONFIG_OFFSET[11:2]) begin
        next_cfg = merged[GSS_CONFIG_BITS-1:0];
      end else if (waddr[11:2] == GSS_TIMECONST_OFFSET[11:2]) begin
        if (wstrb[0]) begin
          next_time_const = wdata[GSS_TC_BITS-1:0];
        end
      end else if (waddr[11:2] == GSS_STATUS_OFFSET[11:2]) begin
        next_bresp = GSS_RESP_OKAY;
      end else if (waddr[11:8] == GSS_TABLE_PAGE) begin
        // Table words are written whole; a mask missing lane 0 or 1 is dropped.
        tbl_wr_en = (wstrb[1:0] == 2'h3);
      end else begin
        next_bresp = GSS_RESP_SLVERR;
      end
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready = !next_w_hold && !next_bvalid;
  end

  always_comb begin
    next_rd_state = rd_state;
    next_raddr = raddr;
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    case (rd_state)
      GSS_RD_IDLE: begin
        next_arready = 1'b1;
        if (s_axi_arvalid && s_axi_arready) begin
          next_raddr = s_axi_araddr;
          next_arready = 1'b0;
          next_rd_state = GSS_RD_WAIT;
        end
      end
      GSS_RD_WAIT: begin
        next_rd_state = GSS_RD_FETCH;
      end
      GSS_RD_FETCH: begin
        next_rvalid = 1'b1;
        next_rresp = GSS_RESP_OKAY;
        next_rdata = 32'h0;
        next_rd_state = GSS_RD_RESP;
        if (raddr[11:2] == GSS_CONFIG_OFFSET[11:2]) begin
          next_rdata = cfg_word;
        end else if (raddr[11:2] == GSS_TIMECONST_OFFSET[11:2]) begin
          next_rdata[GSS_TC_BITS-1:0] = time_const;
        end else if (raddr[11:2] == GSS_STATUS_OFFSET[11:2]) begin
          next_rdata[1:0] = active_set;
        end else if (raddr[11:8] == GSS_TABLE_PAGE) begin
          next_rdata[PARAM_WIDTH-1:0] = tbl_rd_data;
        end else begin
          next_rresp = GSS_RESP_SLVERR;
        end
      end
      GSS_RD_RESP: begin
        if (s_axi_rready) begin
          next_rvalid = 1'b0;
          next_arready = 1'b1;
          next_rd_state = GSS_RD_IDLE;
        end
      end
      default: begin
        next_rd_state = GSS_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= GSS_CONFIG_RESET;
      time_const <= GSS_TC_RESET;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      waddr <= 12'h000;
      wdata <= 32'h0;
      wstrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= GSS_RESP_OKAY;
      rd_state <= GSS_RD_IDLE;
      raddr <= 12'h000;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= GSS_RESP_OKAY;
    end else begin
      cfg <= next_cfg;
      time_const <= next_time_const;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      rd_state <= next_rd_state;
      raddr <= next_raddr;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ****
  // Gain set selection
  // ****
  gss_set_type next_active_set;
  gss_mode_type mode_prev, next_mode_prev;
  logic stop_pending, next_stop_pending;
  logic [15:0] next_status1, next_status5;
  logic signed [31:0] dir_cmd;
  logic is_pos_mode, stop_en, req1, req2;

  always_comb begin
    req1 = control_word1[GSS_REQUEST_BIT];
    req2 = control_word5[GSS_REQUEST_BIT];
    is_pos_mode = (motion.mode == GSS_MODE_POSITION) ||
                  (motion.mode == GSS_MODE_POSITIONING);
    dir_cmd = (motion.mode == GSS_MODE_VELOCITY) ? motion.speed_cmd :
              motion.pulse_freq;
    stop_en = cfg.stop_time_switch_select &&
              (cfg.second_gain_source_select == GSS_SRC2_SAME);
    next_active_set = active_set;
    next_mode_prev = motion.mode;
    next_stop_pending = (motion.mode == GSS_MODE_VELOCITY) && stop_en &&
                        (dir_cmd == 32'sh0) && motion.zero_speed_flag;
    case (cfg.gain_source_select)
      GSS_SRC_COMMAND: begin
        if (req2 && cfg.second_gain_source_select == GSS_SRC2_COMMAND) begin
          next_active_set = GSS_SET_SECOND;
        end else if (req1) begin
          next_active_set = GSS_SET_FIRST;
        end else begin
          next_active_set = GSS_SET_BASE;
        end
      end
      GSS_SRC_DIRECTION: begin
        if (is_pos_mode && mode_prev == GSS_MODE_VELOCITY &&
            stop_pending) begin
          next_active_set = GSS_SET_SECOND;
        end else if (dir_cmd > 32'sh0) begin
          next_active_set = GSS_SET_BASE;
        end else if (dir_cmd < 32'sh0) begin
          next_active_set = GSS_SET_FIRST;
        end else if (is_pos_mode && motion.in_position_flag && stop_en) begin
          next_active_set = GSS_SET_SECOND;
        end
      end
      default: begin
        next_active_set = GSS_SET_BASE;
      end
    endcase
    next_status1 = 16'h0;
    next_status5 = 16'h0;
    next_status1[GSS_REQUEST_BIT] = (next_active_set == GSS_SET_FIRST);
    next_status5[GSS_REQUEST_BIT] = (next_active_set == GSS_SET_SECOND);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_set <= GSS_SET_BASE;
      mode_prev <= GSS_MODE_POSITION;
      stop_pending <= 1'b0;
      status_word1 <= 16'h0;
      status_word5 <= 16'h0;
    end else begin
      active_set <= next_active_set;
      mode_prev <= next_mode_prev;
      stop_pending <= next_stop_pending;
      status_word1 <= next_status1;
      status_word5 <= next_status5;
    end
  end

  // ****
  // Table scan and ramp
  // ****
  // The scan fetches one entry of the active set per cycle, which keeps
  // the table a plain memory at the cost of a 13-cycle refresh round.
  logic [3:0] scan_index, next_scan_index;
  logic [3:0] step_index, next_step_index;
  logic step_en, next_step_en;

  always_comb begin
    next_step_en = 1'b1;
    next_step_index = scan_index;
    if (scan_index == 4'(NUM_PARAMS - 1)) begin
      next_scan_index = 4'h0;
    end else begin
      next_scan_index = scan_index + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_index <= 4'h0;
      step_index <= 4'h0;
      step_en <= 1'b0;
    end else begin
      scan_index <= next_scan_index;
      step_index <= next_step_index;
      step_en <= next_step_en;
    end
  end

  logic [PARAM_WIDTH-1:0] scan_data;

  // whole set from one table page
  gss_table_mem #(
    .WIDTH(PARAM_WIDTH),
    .AW(GSS_TABLE_AW)
  ) u_table (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(tbl_wr_en),
    .wr_addr(waddr[GSS_TABLE_AW+1:2]),
    .wr_data(wdata[PARAM_WIDTH-1:0]),
    .rd_a_addr({active_set, scan_index}),
    .rd_a_data(scan_data),
    .rd_b_addr(raddr[GSS_TABLE_AW+1:2]),
    .rd_b_data(tbl_rd_data)
  );

  gss_gain_ramp #(
    .WIDTH(PARAM_WIDTH),
    .COUNT(NUM_PARAMS)
  ) u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .step_en(step_en),
    .step_index(step_index),
    .target(scan_data),
    .shift(time_const),
    .gain_out(gain_out)
  );
endmodule

// ==== verification/gss_selector_assertions.sv ====
// Checker bound to the gain set selector, watching its ports only.
`timescale 1ns/10ps
module gss_selector_assertions
  import gss_pkg::*;
(
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic [11:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic s_axi_bvalid, // Response valid.
  input wire logic s_axi_bready, // Response ready.
  input wire logic [1:0] s_axi_bresp, // Response code.
  input wire logic [15:0] control_word1, // Request word one.
  input wire logic [15:0] control_word5, // Request word five.
  input wire gss_pkg::gss_motion_type motion, // Commands and mode.
  input wire logic [15:0] status_word1, // Status word one.
  input wire logic [15:0] status_word5, // Status word five.
  input wire gss_pkg::gss_set_type active_set // Selected set.
);
  // ****
  // Configuration shadow
  // ****
  // The shadow lags the design by one edge, so checks skip bvalid.
  logic [11:0] aw_q, next_aw_q;
  logic [9:0] wd_q, next_wd_q;
  gss_cfg_type cfg_q, next_cfg_q;
  gss_mode_type mode_q;
  logic stop_q, d5, st2, same, pos;
  logic signed [31:0] dir;
  gss_set_type cmd_set;
  always_comb begin
    next_aw_q = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : aw_q;
    next_wd_q = s_axi_wvalid && s_axi_wready ? s_axi_wdata[9:0] : wd_q;
    next_cfg_q = cfg_q;
    if (s_axi_bvalid && s_axi_bready && s_axi_bresp == GSS_RESP_OKAY &&
        aw_q == GSS_CONFIG_OFFSET) begin
      next_cfg_q = gss_cfg_type'(wd_q);
    end
  end
  always_ff @(posedge aclk) begin
    aw_q <= next_aw_q;
    wd_q <= next_wd_q;
    cfg_q <= aresetn ? next_cfg_q : GSS_CONFIG_RESET;
    mode_q <= motion.mode;
    stop_q <= motion.speed_cmd == 0 && motion.zero_speed_flag;
  end
  assign d5 = !s_axi_bvalid &&
    cfg_q.gain_source_select == GSS_SRC_DIRECTION;
  assign st2 = cfg_q.stop_time_switch_select &&
    cfg_q.second_gain_source_select == GSS_SRC2_SAME;
  assign same = motion.mode == mode_q;
  assign pos = motion.mode == GSS_MODE_POSITION ||
    motion.mode == GSS_MODE_POSITIONING;
  assign dir = motion.mode == GSS_MODE_VELOCITY ? motion.speed_cmd :
    motion.pulse_freq;
  assign cmd_set = cfg_q.second_gain_source_select == GSS_SRC2_COMMAND &&
    control_word5[GSS_REQUEST_BIT] ? GSS_SET_SECOND :
    control_word1[GSS_REQUEST_BIT] ? GSS_SET_FIRST : GSS_SET_BASE;
  // ****
  // Properties
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  status_first_a: assert property (
    status_word1 == {11'h000, active_set == GSS_SET_FIRST, 4'h0})
    else $error("status word one wrong");
  status_second_a: assert property (
    status_word5 == {11'h000, active_set == GSS_SET_SECOND, 4'h0})
    else $error("status word five wrong");
  cmd_select_a: assert property (
    !s_axi_bvalid && cfg_q.gain_source_select == GSS_SRC_COMMAND
    |=> active_set == $past(cmd_set)) else $error("command set wrong");
  dir_base_a: assert property (d5 && same && dir > 0
    |=> active_set == GSS_SET_BASE) else $error("positive set wrong");
  dir_first_a: assert property (d5 && same && dir < 0
    |=> active_set == GSS_SET_FIRST) else $error("negative set wrong");
  stop_second_a: assert property (d5 && st2 && pos && same &&
    motion.pulse_freq == 0 && motion.in_position_flag
    |=> active_set == GSS_SET_SECOND) else $error("stop set wrong");
  pos_hold_a: assert property (d5 && pos && same &&
    motion.pulse_freq == 0 && !motion.in_position_flag
    |=> $stable(active_set)) else $error("position hold lost");
  vel_hold_a: assert property (d5 && same &&
    motion.mode == GSS_MODE_VELOCITY && motion.speed_cmd == 0
    |=> $stable(active_set)) else $error("velocity hold lost");
  torque_hold_a: assert property (d5 && same &&
    motion.mode == GSS_MODE_TORQUE && motion.pulse_freq == 0
    |=> $stable(active_set)) else $error("torque hold lost");
  mode_keep_a: assert property (d5 && !same &&
    motion.mode == GSS_MODE_VELOCITY && motion.speed_cmd == 0 &&
    active_set == GSS_SET_SECOND |=> active_set == GSS_SET_SECOND)
    else $error("second set lost on mode change");
  return_second_a: assert property (d5 && st2 && stop_q &&
    mode_q == GSS_MODE_VELOCITY && motion.mode == GSS_MODE_POSITION
    |=> active_set == GSS_SET_SECOND) else $error("return set wrong");
  cover property (d5 && st2 && stop_q && mode_q == GSS_MODE_VELOCITY &&
    motion.mode == GSS_MODE_POSITION);
  cover property (active_set == GSS_SET_SECOND && !s_axi_bvalid);
  cover property (s_axi_bvalid && s_axi_bresp == GSS_RESP_SLVERR);
endmodule

bind gss_selector gss_selector_assertions chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .control_word1(control_word1), .control_word5(control_word5),
  .motion(motion), .status_word1(status_word1),
  .status_word5(status_word5), .active_set(active_set)
);

// ==== verification/gss_ctrl_model.sv ====
// Behavioural motion controller that drives the gain request words.
`timescale 1ns/10ps
module gss_ctrl_model (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic [1:0] want, // Bit 0 asks set one, bit 1 set two.
  output logic [15:0] control_word1, // Request word one.
  output logic [15:0] control_word5 // Request word five.
);
  // The other bits carry noise, so a decoder that reads them is caught.
  // request on bit four
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_word1 <= 16'h0000;
      control_word5 <= 16'h0000;
    end else begin
      control_word1 <= (16'($urandom) & 16'hffef) | {11'h000, want[0], 4'h0};
      control_word5 <= (16'($urandom) & 16'hffef) | {11'h000, want[1], 4'h0};
    end
  end
endmodule

// ==== verification/tb_gss_selector.sv ====
// Self-checking testbench for the gain set selector.
`timescale 1ns/10ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
module tb_gss_selector;
  import gss_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, want, w;
  logic [15:0] cw1, cw5, st1, st5;
  gss_motion_type motion;
  gss_set_type act, e;
  logic [12:0][15:0] gain;
  logic [12:0][15:0] tbl [3];
  logic signed [31:0] v;
  int mismatches, total_checks, k;

  gss_selector dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .control_word1(cw1),
    .control_word5(cw5), .motion(motion), .status_word1(st1),
    .status_word5(st5), .active_set(act), .gain_out(gain));
  gss_ctrl_model ctrl (.aclk(aclk), .aresetn(aresetn), .want(want),
    .control_word1(cw1), .control_word5(cw5));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic results();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic stall();
    mismatches++;
    $display("ERROR %0t: no answer in time", $time);
    results();
  endtask

  // Valid and payload are held until each channel's own ready is seen.
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n > 40) stall();
    end while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, r)
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n > 40) stall();
    end while (!rvalid);
    rd_data = rdata;
    rready <= 1'b0;
    `CHK(rresp, r)
    @(posedge aclk);
  endtask

  // Requests pass the model, then the selector.
  task automatic expect_set(input gss_set_type x);
    repeat (3) @(posedge aclk);
    `CHK(act, x)
    `CHK(st1, {11'h000, x == GSS_SET_FIRST, 4'h0})
    `CHK(st5, {11'h000, x == GSS_SET_SECOND, 4'h0})
    rd(GSS_STATUS_OFFSET, GSS_RESP_OKAY);
    `CHK(rd_data[1:0], 2'(x))
  endtask

  // The unused command has the other sign.
  task automatic step(input gss_mode_type m, input logic signed [31:0] c,
                      input logic ip, input logic zs, input gss_set_type x);
    gss_motion_type s;
    s.mode = m;
    s.pulse_freq = (m == GSS_MODE_VELOCITY) ? ~c : c;
    s.speed_cmd = (m == GSS_MODE_VELOCITY) ? c : ~c;
    s.in_position_flag = ip;
    s.zero_speed_flag = zs;
    motion <= s;
    expect_set(x);
  endtask

  task automatic wait_gain(input int s);
    k = 0;
    while (gain !== tbl[s]) begin
      @(posedge aclk);
      k++;
      if (k > 4000) stall();
    end
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, want} = '0;
    wstrb = 4'hf;
    motion = '0;
    void'($urandom(84));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(GSS_CONFIG_OFFSET, GSS_RESP_OKAY);
    `CHK(rd_data[9:0], GSS_CONFIG_RESET)
    rd(GSS_TIMECONST_OFFSET, GSS_RESP_OKAY);
    `CHK(rd_data[3:0], GSS_TC_RESET)
    rd(12'h00c, GSS_RESP_SLVERR);
    wr(12'h00c, 32'h0000_0001, GSS_RESP_SLVERR);
    wr(GSS_CONFIG_OFFSET, 32'h0000_0011, GSS_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      w = (i < 4) ? 2'(i) : 2'($urandom);
      want <= w;
      e = w[1] ? GSS_SET_SECOND : w[0] ? GSS_SET_FIRST : GSS_SET_BASE;
      expect_set(e);
    end
    wr(GSS_CONFIG_OFFSET, 32'h0000_0001, GSS_RESP_OKAY);
    want <= 2'b11;
    expect_set(GSS_SET_FIRST);
    wr(GSS_CONFIG_OFFSET, 32'h0000_0003, GSS_RESP_OKAY);
    expect_set(GSS_SET_BASE);
    for (int t = 0; t < 2; t++) begin
      wr(GSS_CONFIG_OFFSET, 32'h0000_0025 | (t << 9), GSS_RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
        v = $urandom | 1;
        e = (v < 0) ? GSS_SET_FIRST : GSS_SET_BASE;
        step(gss_mode_type'(i % 3), v, 1'($urandom), 1'($urandom), e);
      end
      step(GSS_MODE_POSITION, 0, 1'b1, 1'b0, e);
    end
    wr(GSS_CONFIG_OFFSET, 32'h0000_0125, GSS_RESP_OKAY);
    step(GSS_MODE_POSITION, -5, 1'b0, 1'b0, GSS_SET_FIRST);
    step(GSS_MODE_POSITION, 0, 1'b0, 1'b0, GSS_SET_FIRST);
    step(GSS_MODE_POSITION, 0, 1'b1, 1'b0, GSS_SET_SECOND);
    step(GSS_MODE_VELOCITY, 0, 1'b0, 1'b0, GSS_SET_SECOND);
    step(GSS_MODE_VELOCITY, 7, 1'b0, 1'b0, GSS_SET_BASE);
    step(GSS_MODE_VELOCITY, 0, 1'b0, 1'b1, GSS_SET_BASE);
    step(GSS_MODE_POSITION, 0, 1'b0, 1'b0, GSS_SET_SECOND);
    step(GSS_MODE_TORQUE, -3, 1'b1, 1'b0, GSS_SET_FIRST);
    step(GSS_MODE_TORQUE, 0, 1'b1, 1'b0, GSS_SET_FIRST);
    wr(GSS_CONFIG_OFFSET, 32'h0000_0011, GSS_RESP_OKAY);
    wr(GSS_TIMECONST_OFFSET, 32'h0000_0000, GSS_RESP_OKAY);
    for (int s = 0; s < 3; s++) begin
      for (int p = 0; p < 13; p++) begin
        tbl[s][p] = 16'(s * 16'h5000) | (16'($urandom) & 16'h0fff);
        wr({GSS_TABLE_PAGE, 8'h00} + 12'(4 * (s * 16 + p)),
           32'(tbl[s][p]), GSS_RESP_OKAY);
      end
    end
    for (int s = 2; s >= 0; s--) begin
      want <= 2'((1 << s) >> 1);
      wait_gain(s);
      `CHK(gain, tbl[s])
    end
    wr(GSS_TIMECONST_OFFSET, 32'h0000_0004, GSS_RESP_OKAY);
    want <= 2'b01;
    k = 0;
    while (gain[0] === tbl[0][0]) begin
      @(posedge aclk);
      k++;
      if (k > 100) stall();
    end
    `CHK(gain[0], tbl[0][0] + ((tbl[1][0] - tbl[0][0]) >> 4))
    wait_gain(1);
    `CHK(gain, tbl[1])
    results();
  end
endmodule
